// >>> hw/arbiter_pkg.sv
/*
 * Constants, register map and carrier types of the exception priority arbiter.
 * Assumes a 32-bit APB slave at word-aligned offsets and a 64-entry vector space.
 */
package arbiter_pkg;

    // ****************************************
    // vector positions
    // ****************************************
    localparam int NUM_POS = 64;
    localparam int IRQ_LINES = 48;
    localparam int SYS_HANDLERS = 7;
    localparam int PRIO_W = 3;
    localparam logic [5:0] POS_STACK_TOP = 6'h00;
    localparam logic [5:0] POS_RESET = 6'h01;
    localparam logic [5:0] POS_NMI = 6'h02;
    localparam logic [5:0] POS_HARD = 6'h03;
    localparam logic [5:0] POS_MEM = 6'h04;
    localparam logic [5:0] POS_BUS = 6'h05;
    localparam logic [5:0] POS_USAGE = 6'h06;
    localparam logic [5:0] POS_SVC = 6'h0B;
    localparam logic [5:0] POS_DBG = 6'h0C;
    localparam logic [5:0] POS_PSV = 6'h0E;
    localparam logic [5:0] POS_TICK = 6'h0F;
    localparam logic [5:0] POS_IRQ_BASE = 6'h10;
    localparam logic [5:0] SYS_POS [SYS_HANDLERS] = '{POS_MEM, POS_BUS, POS_USAGE, POS_SVC, POS_DBG, POS_PSV, POS_TICK};
    // lines wired to a source; all others stay reserved
    localparam logic [47:0] IRQ_IMPL_MASK = 48'h0881_F3FF_FFFF;

    // ****************************************
    // internal levels, lower is more urgent
    // ****************************************
    localparam logic [3:0] LVL_RESET = 4'h0;
    localparam logic [3:0] LVL_SETTABLE = 4'h3;
    localparam logic [3:0] LVL_BASE = 4'hF;
    localparam logic [2:0] PRIO_RST = 3'h0;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SWSET = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_EN_LO = 12'h00C;
    localparam logic [11:0] OFF_EN_HI = 12'h010;
    localparam logic [11:0] OFF_PEND_LO = 12'h014;
    localparam logic [11:0] OFF_PEND_HI = 12'h018;
    localparam logic [11:0] OFF_SYS_PRIO = 12'h01C;
    localparam logic [11:0] OFF_IRQ_PRIO = 12'h020;
    localparam int IRQ_PRIO_WORDS = 6;
    localparam int FIELD_PITCH = 4;
    localparam int CTRL_MEM_EN = 0;
    localparam int CTRL_BUS_EN = 1;
    localparam int CTRL_USAGE_EN = 2;
    localparam int CTRL_DBG_EN = 3;
    localparam int CTRL_GRP_LSB = 4;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam int SWSET_NMI = 0;
    localparam int SWSET_PSV_SET = 1;
    localparam int SWSET_PSV_CLR = 2;

    typedef struct packed {
        logic req;
        logic sp_load;
        logic [5:0] vector;
    } exc_out_type;

endpackage

// >>> hw/exception_priority_arbiter.sv
/*
 * Exception priority arbiter: pends system exceptions and external interrupt
 * lines, ranks them and hands the winning vector to the core.
 * Assumes the core acknowledges the shown vector with exc_ack, reports handler
 * exit with exc_return and ret_vector, and does its own stacking.
 */
// Overview of operation
// - eight levels on seven handlers, 33 lines
// - every settable priority resets to zero
// - settable zero ranks after reset, NMI, hard
// - equal level: lower position wins
// - reset position 1, level -3, then base
// - position 0 supplies initial stack pointer
// - NMI position 2, level -2, software only
// - blocked or disabled fault escalates to hard, imprecise bus fault only when disabled
// - memory fault position 4, settable priority
// - bus fault position 5, enableable, precise/imprecise
// - usage fault position 6, synchronous
// - supervisor call position 11, synchronous
// - debug monitor only when enabled, must preempt
// - pendable request position 14, software only
// - tick timer position 15 on expiry
// - external lines from 16, asynchronous, prioritised
// - source lines map to fixed bit numbers
// - reserved lines never asserted
// - preempt part preempts, subpriority only orders
// - vector given during core stacking
// - pending at return tail-chains, no restack
module exception_priority_arbiter
    import arbiter_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [IRQ_LINES-1:0] irq_async,
    input wire logic tick_async,
    input wire logic mem_fault,
    input wire logic bus_fault_precise,
    input wire logic bus_fault_imprecise,
    input wire logic usage_fault,
    input wire logic svc_call,
    input wire logic debug_event,
    input wire logic exc_ack,
    input wire logic exc_return,
    input wire logic [5:0] ret_vector,
    output exc_out_type exc_out,
    output logic tail_chain,
    output logic unstack
);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************
    // state
    // ****************************************
    logic [5:0] ctrl_r;
    logic [IRQ_LINES-1:0] irq_en_r;
    logic [PRIO_W-1:0] pos_prio_r [NUM_POS];
    logic [NUM_POS-1:0] pend_r, pend_nxt, pend_set, pend_clr;
    logic [NUM_POS-1:0] act_r, act_nxt, act_eff, en_pos, cand;
    logic [IRQ_LINES:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;
    logic pready_r, pslverr_r, tail_chain_r, unstack_r;
    logic [31:0] prdata_r;
    exc_out_type exc_out_r;
    logic [3:0] full_pri [NUM_POS];
    logic [3:0] pre_pri [NUM_POS];
    logic [3:0] cur_pre, best;
    logic [5:0] win;
    logic win_valid, req_c;

    // ****************************************
    // apb decode
    // ****************************************
    wire access = psel & penable;
    wire commit = access & pready_r;
    wire wr = commit & pwrite;
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_swset = paddr == OFF_SWSET;
    wire hit_status = paddr == OFF_STATUS;
    wire hit_en_lo = paddr == OFF_EN_LO;
    wire hit_en_hi = paddr == OFF_EN_HI;
    wire hit_pend_lo = paddr == OFF_PEND_LO;
    wire hit_pend_hi = paddr == OFF_PEND_HI;
    wire hit_sys = paddr == OFF_SYS_PRIO;
    wire [11:0] prio_off = paddr - OFF_IRQ_PRIO;
    wire hit_prio = paddr >= OFF_IRQ_PRIO && prio_off[11:2] < 10'(IRQ_PRIO_WORDS) && paddr[1:0] == 2'b00;
    wire hit_any = hit_ctrl | hit_swset | hit_status | hit_en_lo | hit_en_hi | hit_pend_lo | hit_pend_hi
        | hit_sys | hit_prio;
    wire [2:0] prio_word = prio_off[4:2];
    wire [2:0] grp_mask = 3'h7 << ctrl_r[CTRL_GRP_LSB +: 2];
    wire sw_nmi = wr & hit_swset & pwdata[SWSET_NMI];
    wire sw_psv_set = wr & hit_swset & pwdata[SWSET_PSV_SET];
    wire sw_psv_clr = wr & hit_swset & pwdata[SWSET_PSV_CLR];

    // ****************************************
    // pin synchronisers and tick edge
    // ****************************************
    // a level moves only once the second and third stages agree
    assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    wire tick_evt = lvl_nxt[IRQ_LINES] & ~lvl_r[IRQ_LINES];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end else begin
            s1_r <= {tick_async, irq_async};
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    // ****************************************
    // ranking
    // ****************************************
    always_comb begin
        for (int p = 0; p < NUM_POS; p++) begin
            if (p >= 1 && p <= 3) begin
                full_pri[p] = 4'(p - 1);
                pre_pri[p] = 4'(p - 1);
            end else begin
                full_pri[p] = LVL_SETTABLE + {1'b0, pos_prio_r[p]};
                pre_pri[p] = LVL_SETTABLE + {1'b0, pos_prio_r[p] & grp_mask};
            end
        end
    end

    assign en_pos = {irq_en_r & IRQ_IMPL_MASK, 16'h0000} | (64'h1 << POS_RESET) | (64'h1 << POS_NMI)
        | (64'h1 << POS_HARD) | (64'({ctrl_r[CTRL_MEM_EN]}) << POS_MEM) | (64'({ctrl_r[CTRL_BUS_EN]}) << POS_BUS)
        | (64'({ctrl_r[CTRL_USAGE_EN]}) << POS_USAGE) | (64'h1 << POS_SVC)
        | (64'({ctrl_r[CTRL_DBG_EN]}) << POS_DBG) | (64'h1 << POS_PSV) | (64'h1 << POS_TICK);
    assign cand = pend_r & en_pos;
    // the handler that returns in this cycle no longer holds the level
    assign act_eff = exc_return ? act_r & ~(64'h1 << ret_vector) : act_r;

    always_comb begin
        best = LVL_BASE;
        win = POS_STACK_TOP;
        win_valid = 1'b0;
        cur_pre = LVL_BASE;
        for (int p = NUM_POS - 1; p >= 0; p--) begin
            if (cand[p] && full_pri[p] <= best) begin
                best = full_pri[p];
                win = 6'(p);
                win_valid = 1'b1;
            end
            if (act_eff[p] && pre_pri[p] < cur_pre) begin
                cur_pre = pre_pri[p];
            end
        end
    end

    assign req_c = win_valid && pre_pri[win] < cur_pre;

    // ****************************************
    // pending and active sets
    // ****************************************
    // a fault that cannot run at its own level goes to the hard fault; an imprecise bus fault goes there only when disabled
    wire mem_ok = ctrl_r[CTRL_MEM_EN] && pre_pri[POS_MEM] < cur_pre;
    wire bus_ok = ctrl_r[CTRL_BUS_EN] && pre_pri[POS_BUS] < cur_pre;
    wire usage_ok = ctrl_r[CTRL_USAGE_EN] && pre_pri[POS_USAGE] < cur_pre;
    wire svc_ok = pre_pri[POS_SVC] < cur_pre;
    wire escalate = (mem_fault & ~mem_ok) | (bus_fault_precise & ~bus_ok) | (usage_fault & ~usage_ok)
        | (svc_call & ~svc_ok) | (bus_fault_imprecise & ~ctrl_r[CTRL_BUS_EN]);
    wire dbg_take = debug_event && ctrl_r[CTRL_DBG_EN] && pre_pri[POS_DBG] < cur_pre;

    always_comb begin
        pend_set = '0;
        pend_set[POS_NMI] = sw_nmi;
        pend_set[POS_HARD] = escalate;
        pend_set[POS_MEM] = mem_fault & mem_ok;
        pend_set[POS_BUS] = (bus_fault_precise & bus_ok) | (bus_fault_imprecise & ctrl_r[CTRL_BUS_EN]);
        pend_set[POS_USAGE] = usage_fault & usage_ok;
        pend_set[POS_SVC] = svc_call & svc_ok;
        pend_set[POS_DBG] = dbg_take;
        pend_set[POS_PSV] = sw_psv_set;
        pend_set[POS_TICK] = tick_evt;
        pend_set[NUM_POS-1:16] = lvl_nxt[IRQ_LINES-1:0] & IRQ_IMPL_MASK;
        pend_clr = '0;
        pend_clr[POS_PSV] = sw_psv_clr;
        if (wr && hit_pend_lo) begin
            pend_clr[47:16] = pwdata;
        end
        if (wr && hit_pend_hi) begin
            pend_clr[63:48] = pwdata[15:0];
        end
        if (exc_ack) begin
            pend_clr = pend_clr | (64'h1 << exc_out_r.vector);
        end
    end

    // set wins over clear, so no event is lost
    assign pend_nxt = (pend_r & ~pend_clr) | pend_set;
    // taking the reset vector leaves the core at base level
    assign act_nxt = act_eff | (exc_ack && exc_out_r.vector != POS_RESET ? 64'h1 << exc_out_r.vector : 64'h0);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= 64'h1 << POS_RESET;
            act_r <= '0;
        end else begin
            pend_r <= pend_nxt;
            act_r <= act_nxt;
        end
    end

    // ****************************************
    // core handshake
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_out_r <= '0;
            tail_chain_r <= 1'b0;
            unstack_r <= 1'b0;
        end else begin
            exc_out_r.req <= req_c & ~exc_ack;
            exc_out_r.vector <= win;
            exc_out_r.sp_load <= win == POS_RESET;
            tail_chain_r <= exc_return & req_c;
            unstack_r <= exc_return & ~req_c;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            irq_en_r <= '0;
            for (int p = 0; p < NUM_POS; p++) begin
                pos_prio_r[p] <= PRIO_RST;
            end
        end else if (wr) begin
            if (hit_ctrl) ctrl_r <= pwdata[5:0];
            if (hit_en_lo) irq_en_r[31:0] <= pwdata;
            if (hit_en_hi) irq_en_r[47:32] <= pwdata[15:0];
            for (int i = 0; i < SYS_HANDLERS; i++) begin
                if (hit_sys) pos_prio_r[SYS_POS[i]] <= pwdata[FIELD_PITCH*i +: PRIO_W];
            end
            for (int f = 0; f < 8; f++) begin
                if (hit_prio) pos_prio_r[16 + 8 * prio_word + f] <= pwdata[FIELD_PITCH*f +: PRIO_W];
            end
        end
    end

    logic [31:0] rdata_c;
    always_comb begin
        rdata_c = 32'h0000_0000;
        if (hit_ctrl) rdata_c[5:0] = ctrl_r;
        if (hit_status) rdata_c = {16'h0000, 3'h0, req_c, cur_pre, 2'h0, win};
        if (hit_en_lo) rdata_c = irq_en_r[31:0];
        if (hit_en_hi) rdata_c[15:0] = irq_en_r[47:32];
        if (hit_pend_lo) rdata_c = pend_r[47:16];
        if (hit_pend_hi) rdata_c[15:0] = pend_r[63:48];
        for (int i = 0; i < SYS_HANDLERS; i++) begin
            if (hit_sys) rdata_c[FIELD_PITCH*i +: PRIO_W] = pos_prio_r[SYS_POS[i]];
        end
        for (int f = 0; f < 8; f++) begin
            if (hit_prio) rdata_c[FIELD_PITCH*f +: PRIO_W] = pos_prio_r[16 + 8 * prio_word + f];
        end
    end

    // one wait state keeps pready and prdata straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= access & ~pready_r;
            if (access && !pready_r) begin
                prdata_r <= rdata_c;
                pslverr_r <= ~hit_any;
            end
        end
    end

    assign pready = pready_r;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign exc_out = exc_out_r;
    assign tail_chain = tail_chain_r;
    assign unstack = unstack_r;

    // ****************************************
    // checks
    // ****************************************
    property p_fixed_order;
        cand[POS_HARD] && !cand[POS_RESET] && !cand[POS_NMI] |-> win == POS_HARD;
    endproperty
    a_fixed_order: assert property (p_fixed_order) else $error("hard fault lost to settable source");
    property p_tie;
        cand[POS_IRQ_BASE] && full_pri[POS_IRQ_BASE] <= best |-> win <= POS_IRQ_BASE;
    endproperty
    a_tie: assert property (p_tie) else $error("tie not resolved by position");
    property p_reset_base;
        exc_ack && exc_out_r.vector == POS_RESET |=> !act_r[POS_RESET];
    endproperty
    a_reset_base: assert property (p_reset_base) else $error("reset left active");
    property p_sp_load;
        exc_out_r.req && exc_out_r.vector == POS_RESET |-> exc_out_r.sp_load;
    endproperty
    a_sp_load: assert property (p_sp_load) else $error("stack pointer load missing");
    property p_nmi;
        sw_nmi |=> pend_r[POS_NMI] ##1 (exc_out_r.req || exc_ack || $past(exc_ack));
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not requested");
    property p_escalate;
        mem_fault && !ctrl_r[CTRL_MEM_EN] |=> pend_r[POS_HARD] || $past(exc_ack);
    endproperty
    a_escalate: assert property (p_escalate) else $error("disabled fault did not escalate");
    property p_reserved;
        (pend_r[NUM_POS-1:16] & ~IRQ_IMPL_MASK) == 48'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved line pending");
    property p_hold;
        pend_r[POS_IRQ_BASE] && !pend_clr[POS_IRQ_BASE] |=> pend_r[POS_IRQ_BASE];
    endproperty
    a_hold: assert property (p_hold) else $error("pending line dropped");
    property p_tail;
        exc_return && req_c |=> tail_chain_r && !unstack_r ##1 !tail_chain_r;
    endproperty
    a_tail: assert property (p_tail) else $error("tail chain not signalled");
    property p_dbg_off;
        debug_event && !ctrl_r[CTRL_DBG_EN] && !pend_r[POS_DBG] |=> !pend_r[POS_DBG];
    endproperty
    a_dbg_off: assert property (p_dbg_off) else $error("disabled debug monitor pended");
    property p_irq_lat;
        $rose(lvl_r[0]) && irq_en_r[0] |-> ##[0:2] pend_r[0 + 16] || $past(exc_ack);
    endproperty
    a_irq_lat: assert property (p_irq_lat) else $error("line not pended");

    c_tail: cover property (exc_return && req_c);
    c_escalate: cover property (escalate);
    c_irq_taken: cover property (exc_ack && exc_out_r.vector >= POS_IRQ_BASE);
    c_nmi: cover property (exc_out_r.req && exc_out_r.vector == POS_NMI);

endmodule // exception_priority_arbiter

// >>> sim/core_model.sv
/*
 * Core-side partner: takes the shown vector after a chosen delay, runs each
 * handler a few cycles, then returns from the newest one first.
 * Assumes the arbiter package and the arbiter's clock and reset.
 */
module core_model
    import arbiter_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] delay,
    input wire exc_out_type exc_out,
    output logic exc_ack,
    output logic exc_return,
    output logic [5:0] ret_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] stk [$];
    int run;
    int wait_n;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exc_ack <= 1'b0;
            exc_return <= 1'b0;
            ret_vector <= 6'h00;
            run = 0;
            wait_n = 0;
            stk.delete();
        end else begin
            exc_ack <= 1'b0;
            exc_return <= 1'b0;
            if (exc_out.req && !exc_ack) begin
                ret_vector <= ~ret_vector;
                if (wait_n >= delay) begin
                    // stacking runs alongside the vector take
                    exc_ack <= 1'b1;
                    wait_n = 0;
                    run = 0;
                    if (exc_out.vector != POS_RESET) stk.push_back(exc_out.vector);
                end else wait_n++;
            end else if (stk.size() > 0 && !exc_return && run == 5) begin
                exc_return <= 1'b1;
                ret_vector <= stk.pop_back();
                run = 0;
            end else begin
                // an idle return bus flips every cycle, so it shows the last vector every other cycle
                ret_vector <= ~ret_vector;
                if (stk.size() > 0) run++;
            end
        end
    end
endmodule // core_model

// >>> sim/exception_priority_arbiter_tb.sv
/*
 * Self-checking bench for the exception priority arbiter.
 * Assumes the core partner model and an APB master held by this bench.
 */
module exception_priority_arbiter_tb import arbiter_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tick, exc_ack, exc_return, tail_chain, unstack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [47:0] irq, en;
    logic [5:0] pulse, ret_vector, v_exp;
    logic [3:0] delay;
    exc_out_type exc_out;
    logic [5:0] exp_v [$];
    logic [32:0] exp_rd [$];
    logic [31:0] shadow [IRQ_PRIO_WORDS];
    logic [7:0] seed = 8'h4F;
    logic [2:0] pa, pb;
    int a, b, first, error_cnt, num_checks, cycles, chains, unstacks;
    // none marks a source that must not be taken
    localparam logic [5:0] EXP_EXC [12] = '{6'h03, 6'h03, 6'h03, 6'h3F, 6'h0B, 6'h03,
                                            6'h04, 6'h05, 6'h06, 6'h0C, 6'h0B, 6'h05};

    exception_priority_arbiter dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .irq_async(irq), .tick_async(tick), .mem_fault(pulse[0]),
        .bus_fault_precise(pulse[1]), .usage_fault(pulse[2]), .debug_event(pulse[3]),
        .svc_call(pulse[4]), .bus_fault_imprecise(pulse[5]), .exc_ack(exc_ack),
        .exc_return(exc_return), .ret_vector(ret_vector), .exc_out(exc_out),
        .tail_chain(tail_chain), .unstack(unstack));
    core_model core (.pclk(pclk), .presetn(presetn), .delay(delay), .exc_out(exc_out),
        .exc_ack(exc_ack), .exc_return(exc_return), .ret_vector(ret_vector));

    // ****************************************
    // helpers
    // ****************************************
    function automatic int pick();
        do seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        while (!IRQ_IMPL_MASK[seed % 48]);
        return seed % 48;
    endfunction
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] adr, input logic [31:0] d, input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= adr;
        pwdata <= d;
        if (!w) exp_rd.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // waits for every noted vector to be taken, then 20 cycles for the handlers to return
    task automatic settle;
        int n;
        n = 0;
        while (exp_v.size() > 0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        repeat (20) @(posedge pclk);
        check("vectors left", 33'(exp_v.size()), 33'h0);
    endtask

    // ****************************************
    // monitor and timeout
    // ****************************************
    always @(posedge pclk) begin
        cycles++;
        if (psel && penable && pready && !pwrite) begin
            if (exp_rd.size() == 0) check("read", {pslverr, prdata}, 33'h1FFFFFFFF);
            else check("read", {pslverr, prdata}, exp_rd.pop_front());
        end
        if (exc_ack && exc_out.req) begin
            v_exp = (exp_v.size() == 0) ? 6'h3F : exp_v.pop_front();
            check("exc_out", {25'h0, exc_out}, {25'h0, 1'b1, v_exp == POS_RESET, v_exp});
        end
        // every handler exit ends in exactly one of these pulses
        if (tail_chain) chains++;
        if (unstack) unstacks++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, tick} = '0;
        {paddr, pwdata, irq, pulse, delay} = '0;
        exp_v.push_back(POS_RESET);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_CTRL, 32'h0, 33'h0);
        apb(1'b0, OFF_SYS_PRIO, 32'h0, 33'h0);
        for (int w = 0; w < IRQ_PRIO_WORDS; w++) apb(1'b0, OFF_IRQ_PRIO + 12'(4 * w), 32'h0, 33'h0);
        apb(1'b0, 12'h038, 32'h0, 33'h100000000);
        irq <= ~IRQ_IMPL_MASK;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFF_PEND_LO, 32'h0, 33'h0);
        apb(1'b0, OFF_PEND_HI, 32'h0, 33'h0);
        irq <= 48'h8;
        repeat (5) @(posedge pclk);
        irq <= '0;
        repeat (6) @(posedge pclk);
        apb(1'b0, OFF_PEND_LO, 32'h0, 33'h8);
        apb(1'b1, OFF_PEND_LO, 32'h8, 33'h0);
        apb(1'b0, OFF_PEND_LO, 32'h0, 33'h0);
        settle();
        apb(1'b0, OFF_STATUS, 32'h0, 33'h00000F00);
        for (int i = 0; i < 12; i++) begin
            if (i == 6) apb(1'b1, OFF_CTRL, 32'h0000000F, 33'h0);
            if (EXP_EXC[i] != 6'h3F) exp_v.push_back(EXP_EXC[i]);
            @(posedge pclk);
            pulse <= 6'(1 << (i % 6));
            @(posedge pclk);
            pulse <= '0;
            settle();
        end
        exp_v.push_back(POS_NMI);
        exp_v.push_back(POS_PSV);
        apb(1'b1, OFF_SWSET, 32'h3, 33'h0);
        settle();
        exp_v.push_back(POS_TICK);
        tick <= 1'b1;
        repeat (6) @(posedge pclk);
        tick <= 1'b0;
        settle();
        // slow core so each line is low again before its vector is taken
        delay <= 4'hA;
        for (int r = 0; r < 4; r++) begin
            a = pick();
            do b = pick(); while (b == a);
            pa = seed[2:0];
            pb = (r == 0) ? pa : seed[5:3];
            shadow = '{default: 32'h0};
            shadow[a / 8] |= 32'(pa) << (FIELD_PITCH * (a % 8));
            shadow[b / 8] |= 32'(pb) << (FIELD_PITCH * (b % 8));
            for (int w = 0; w < IRQ_PRIO_WORDS; w++) apb(1'b1, OFF_IRQ_PRIO + 12'(4 * w), shadow[w], 33'h0);
            apb(1'b0, OFF_IRQ_PRIO + 12'(4 * (a / 8)), 32'h0, {1'b0, shadow[a / 8]});
            en = (48'h1 << a) | (48'h1 << b);
            apb(1'b1, OFF_EN_LO, en[31:0], 33'h0);
            apb(1'b1, OFF_EN_HI, {16'h0, en[47:32]}, 33'h0);
            first = (pb < pa || (pb == pa && b < a)) ? b : a;
            exp_v.push_back(POS_IRQ_BASE + 6'(first));
            exp_v.push_back(POS_IRQ_BASE + 6'(a + b - first));
            irq <= en;
            repeat (4) @(posedge pclk);
            irq <= '0;
            settle();
        end
        // same preempt part: the later, more urgent request must wait for the return
        delay <= 4'h0;
        apb(1'b1, OFF_CTRL, 32'h0000002F, 33'h0);
        apb(1'b1, OFF_SYS_PRIO, 32'h00003000, 33'h0);
        exp_v.push_back(POS_SVC);
        exp_v.push_back(POS_PSV);
        @(posedge pclk);
        pulse <= 6'h10;
        @(posedge pclk);
        pulse <= '0;
        apb(1'b1, OFF_SWSET, 32'h00000002, 33'h0);
        settle();
        check("tail chains", 33'(chains), 33'h6);
        check("unstacks", 33'(unstacks), 33'h12);
        conclude();
    end
endmodule // exception_priority_arbiter_tb
